// File: design/atc_pkg.sv
package atc_pkg;

  // breaker role of this relay in the main-tie-main line-up
  typedef enum logic [1:0] {
    ROLE_OFF,
    ROLE_INC1,
    ROLE_INC2,
    ROLE_TIE
  } role_e;

  // transfer sequence of an incomer relay
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRIP,
    ST_REQ,
    ST_DONE
  } seq_e;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned VOLT_W = 16;
  localparam int unsigned N_IN = 11;

  // contact input positions
  localparam int unsigned IN_LOCKOUT = 0;
  localparam int unsigned IN_SRC_TRIP = 1;
  localparam int unsigned IN_BLOCK = 2;
  localparam int unsigned IN_CONN1 = 3;
  localparam int unsigned IN_CONN2 = 4;
  localparam int unsigned IN_CONNT = 5;
  localparam int unsigned IN_CL1 = 6;
  localparam int unsigned IN_CL2 = 7;
  localparam int unsigned IN_CLT = 8;
  localparam int unsigned IN_SEL = 9;
  localparam int unsigned IN_REQ = 10;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_POL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESID = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0C;

  // values after reset
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [N_IN-1:0] POL_RST = 11'h000;
  localparam logic [VOLT_W-1:0] RESID_RST = 16'h0000;

  // status field positions
  localparam int unsigned ST_NOT_READY = 0;
  localparam int unsigned ST_TRIP_OUT = 1;
  localparam int unsigned ST_TIE_REQ = 2;
  localparam int unsigned ST_PERMIT = 3;
  localparam int unsigned ST_SEQ_LO = 4;
  localparam int unsigned ST_IN_LO = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: design/pin_cond.sv
module pin_cond #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] polarity,
  output logic [W-1:0] asserted
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // polarity bit set: contact is normally closed
  assign asserted = q.s2 ^ polarity;

endmodule // pin_cond

// File: design/axil_slave.sv
module axil_slave (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [atc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [atc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [atc_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  typedef struct packed {
    logic aw_have;
    logic [atc_pkg::ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_s;

  bus_s q, d;

  assign awready = ce & ~q.aw_have & ~q.bvalid;
  assign wready = ce & ~q.w_have & ~q.bvalid;
  assign arready = ce & ~q.rvalid;
  // write commits once both halves are held
  assign wr_en = ce & q.aw_have & q.w_have;
  assign wr_addr = q.aw_addr;
  assign wr_data = q.w_data;
  assign wr_strb = q.w_strb;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;

  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (wr_en) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_ok ? atc_pkg::RESP_OKAY : atc_pkg::RESP_SLVERR;
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_ok ? rd_data : 32'h00000000;
      d.rresp = rd_ok ? atc_pkg::RESP_OKAY : atc_pkg::RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule // axil_slave

// File: design/bus_auto_transfer_control.sv
// How it works
// - block input stops any new transfer start
// - every contact input has selectable polarity
// - lockout, source trip or timed undervoltage start
// - second incomer swaps source one and two
// - any breaker not connected blocks start
// - open opposite incomer blocks start
// - own instantaneous overcurrent blocks start
// - other source definite undervoltage blocks start
// - overcurrent also enables own definite undervoltage block
// - any block raises transfer not ready
// - first step trips own breaker
// - then close request goes to tie
// - trip held until own breaker opens
// - tie latches request until closed or blocked
// - tie close waits for residual voltage permission
// - permission only once bus voltage decayed
// - three closed trips selected breaker
// - aux relays scheme only, deenergized, self resetting
// - role setting off, incomer one, two, tie
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module bus_auto_transfer_control (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [atc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [atc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic transformer_lockout_input,
  input wire logic source_trip_in,
  input wire logic block_transfer_in,
  input wire logic brk1_connected_in,
  input wire logic brk2_connected_in,
  input wire logic tie_connected_in,
  input wire logic brk1_closed_in,
  input wire logic brk2_closed_in,
  input wire logic tie_closed_in,
  input wire logic select_to_trip_in,
  input wire logic close_request_in,
  input wire logic uv_inverse_timeout,
  input wire logic uv_definite_this,
  input wire logic uv_definite_other,
  input wire logic phase_instant_overcurrent,
  input wire logic neutral_instant_overcurrent,
  input wire logic [atc_pkg::VOLT_W-1:0] bus_voltage,
  output logic trip_out,
  output logic [3:0] aux_relay
);

  typedef struct packed {
    atc_pkg::role_e role;
    logic [atc_pkg::N_IN-1:0] pol;
    logic [atc_pkg::VOLT_W-1:0] resid;
    atc_pkg::seq_e st;
    logic tie_req;
    logic trip;
    logic [3:0] aux;
  } core_s;

  core_s q, d;

  logic [atc_pkg::N_IN-1:0] pins, in;
  logic wr_en, wr_ok, rd_ok;
  logic [atc_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic is_inc, is_tie, inc2;
  logic block_in, all_conn, all_closed, ioc, uv_block_this;
  logic own_closed, other_closed;
  logic blocked_inc, not_ready, initiate, start_cond;
  logic pp_trip, perm, close_cmd;

  assign pins = {close_request_in, select_to_trip_in, tie_closed_in,
                 brk2_closed_in, brk1_closed_in, tie_connected_in,
                 brk2_connected_in, brk1_connected_in, block_transfer_in,
                 source_trip_in, transformer_lockout_input};

  // contacts cross from the field: two flops before use
  pin_cond #(
    .W(atc_pkg::N_IN)
  ) u_pins (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .pin_in(pins),
    .polarity(q.pol),
    .asserted(in)
  );

  axil_slave u_bus (
    .clock(clock),
    .arst_n(arst_n),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // role decode
  assign is_inc = (q.role == atc_pkg::ROLE_INC1) ||
                  (q.role == atc_pkg::ROLE_INC2);
  assign is_tie = (q.role == atc_pkg::ROLE_TIE);
  assign inc2 = (q.role == atc_pkg::ROLE_INC2);

  // own and other source exchange on the second incomer
  assign own_closed = inc2 ? in[atc_pkg::IN_CL2]
                           : in[atc_pkg::IN_CL1];
  assign other_closed = inc2 ? in[atc_pkg::IN_CL1]
                             : in[atc_pkg::IN_CL2];

  assign block_in = in[atc_pkg::IN_BLOCK];
  assign all_conn = in[atc_pkg::IN_CONN1] & in[atc_pkg::IN_CONN2] &
                    in[atc_pkg::IN_CONNT];
  assign all_closed = in[atc_pkg::IN_CL1] & in[atc_pkg::IN_CL2] &
                      in[atc_pkg::IN_CLT];
  assign ioc = phase_instant_overcurrent |
               neutral_instant_overcurrent;
  // own dip caused by a load-side fault must not start a transfer
  assign uv_block_this = uv_definite_this & ioc;

  assign blocked_inc = ~all_conn
                     | ~other_closed
                     | ioc
                     | uv_definite_other
                     | uv_block_this
                     | block_in;

  always_comb begin
    not_ready = 1'b0;
    if (is_inc) begin
      not_ready = blocked_inc;
    end else if (is_tie) begin
      not_ready = ~all_conn | block_in;
    end
  end

  assign start_cond = in[atc_pkg::IN_LOCKOUT] | in[atc_pkg::IN_SRC_TRIP] |
                      uv_inverse_timeout;
  assign initiate = is_inc & start_cond & ~blocked_inc;

  // prevent parallel while the scheme is in service
  assign pp_trip = (q.role != atc_pkg::ROLE_OFF) & ~block_in &
                   all_closed & in[atc_pkg::IN_SEL];

  // residual voltage check on the dead bus
  assign perm = (bus_voltage <= q.resid);
  assign close_cmd = is_tie & q.tie_req & perm & ~in[atc_pkg::IN_CLT] &
                     ~block_in;

  // register access
  assign wr_ok = (wr_addr == atc_pkg::OFF_CTRL) ||
                 (wr_addr == atc_pkg::OFF_POL) ||
                 (wr_addr == atc_pkg::OFF_RESID);
  assign rd_ok = (araddr == atc_pkg::OFF_CTRL) ||
                 (araddr == atc_pkg::OFF_POL) ||
                 (araddr == atc_pkg::OFF_RESID) ||
                 (araddr == atc_pkg::OFF_STAT);

  always_comb begin
    rd_data = 32'h00000000;
    case (araddr)
      atc_pkg::OFF_CTRL: rd_data[1:0] = q.role;
      atc_pkg::OFF_POL: rd_data[atc_pkg::N_IN-1:0] = q.pol;
      atc_pkg::OFF_RESID: rd_data[atc_pkg::VOLT_W-1:0] = q.resid;
      atc_pkg::OFF_STAT: begin
        rd_data[atc_pkg::ST_NOT_READY] = q.aux[2];
        rd_data[atc_pkg::ST_TRIP_OUT] = q.trip;
        rd_data[atc_pkg::ST_TIE_REQ] = q.tie_req;
        rd_data[atc_pkg::ST_PERMIT] = perm;
        rd_data[atc_pkg::ST_SEQ_LO +: 2] = q.st;
        rd_data[atc_pkg::ST_IN_LO +: atc_pkg::N_IN] = in;
      end
      default: rd_data = 32'h00000000;
    endcase
  end

  always_comb begin
    d = q;
    if (wr_en && wr_strb[0] && wr_addr == atc_pkg::OFF_CTRL) begin
      d.role = atc_pkg::role_e'(wr_data[1:0]);
    end
    if (wr_en && wr_addr == atc_pkg::OFF_POL) begin
      if (wr_strb[0]) begin
        d.pol[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        d.pol[atc_pkg::N_IN-1:8] = wr_data[atc_pkg::N_IN-1:8];
      end
    end
    if (wr_en && wr_addr == atc_pkg::OFF_RESID) begin
      if (wr_strb[0]) begin
        d.resid[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
        d.resid[15:8] = wr_data[15:8];
      end
    end

    // incomer sequence: trip, then request tie close
    case (q.st)
      atc_pkg::ST_IDLE: begin
        if (initiate) begin
          d.st = atc_pkg::ST_TRIP;
        end
      end
      atc_pkg::ST_TRIP: d.st = atc_pkg::ST_REQ;
      atc_pkg::ST_REQ: begin
        if (!own_closed) begin
          d.st = atc_pkg::ST_DONE;
        end
      end
      atc_pkg::ST_DONE: begin
        // rearm only once the cause has gone
        if (!start_cond) begin
          d.st = atc_pkg::ST_IDLE;
        end
      end
      default: d.st = atc_pkg::ST_IDLE;
    endcase
    if (!is_inc) begin
      d.st = atc_pkg::ST_IDLE;
    end

    // clear wins: a blocked or closed tie must not keep a stale request
    if (!is_tie || in[atc_pkg::IN_CLT] || block_in) begin
      d.tie_req = 1'b0;
    end else if (in[atc_pkg::IN_REQ]) begin
      d.tie_req = 1'b1;
    end

    d.trip = (d.st == atc_pkg::ST_TRIP) || (d.st == atc_pkg::ST_REQ) ||
             pp_trip;
    // level outputs: drop as soon as the cause drops
    d.aux = '0;
    if (q.role != atc_pkg::ROLE_OFF) begin
      d.aux[0] = (d.st == atc_pkg::ST_REQ) ||
                 (d.st == atc_pkg::ST_DONE);
      d.aux[1] = close_cmd;
      d.aux[2] = not_ready;
      d.aux[3] = pp_trip;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q.role <= atc_pkg::role_e'(atc_pkg::CTRL_RST);
      q.pol <= atc_pkg::POL_RST;
      q.resid <= atc_pkg::RESID_RST;
      q.st <= atc_pkg::ST_IDLE;
      q.tie_req <= 1'b0;
      q.trip <= 1'b0;
      q.aux <= 4'h0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign trip_out = q.trip;
  assign aux_relay = q.aux;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_start;
    ce && q.st == atc_pkg::ST_IDLE && initiate;
  endsequence

  sequence s_tripped;
    ce && q.st == atc_pkg::ST_TRIP;
  endsequence

  AST_BLOCK_HOLDS_IDLE: assert property (
    ce && block_in && q.st == atc_pkg::ST_IDLE |=> q.st == atc_pkg::ST_IDLE)
    else $error("transfer started while blocked");

  AST_START_TRIPS: assert property (
    s_start |=> q.trip && q.st == atc_pkg::ST_TRIP)
    else $error("initiation did not trip own breaker");

  AST_UNCONNECTED_BLOCKS: assert property (
    ce && is_inc && !all_conn |-> !initiate ##1 q.aux[2])
    else $error("unconnected breaker did not block");

  AST_OTHER_OPEN_BLOCKS: assert property (
    ce && is_inc && !other_closed && q.st == atc_pkg::ST_IDLE
    |=> q.st == atc_pkg::ST_IDLE)
    else $error("start with new source open");

  AST_REQ_AFTER_TRIP: assert property (
    s_tripped |=> q.aux[0] && q.trip && $past(q.trip))
    else $error("close request not after trip");

  AST_TRIP_HELD: assert property (
    ce && q.st == atc_pkg::ST_REQ && own_closed |=> q.trip)
    else $error("trip dropped before breaker opened");

  AST_TIE_LATCH: assert property (
    ce && q.tie_req && is_tie && !in[atc_pkg::IN_CLT] && !block_in
    |=> q.tie_req)
    else $error("tie request lost");

  AST_CLOSE_NEEDS_PERMIT: assert property (
    $rose(q.aux[1]) |-> $past(perm) && $past(q.tie_req))
    else $error("tie closed without residual permission");

  AST_PARALLEL_TRIP: assert property (
    ce && pp_trip |=> q.trip && q.aux[3])
    else $error("parallel not tripped");

  AST_AUX_IDLE_OFF: assert property (
    ce && q.role == atc_pkg::ROLE_OFF |=> q.aux == 4'h0)
    else $error("aux relay energised while disabled");

endmodule // bus_auto_transfer_control

// File: verif/field_model.sv
module field_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [2:0] preset,
  input wire logic slow,
  input wire logic trip_cmd,
  input wire logic [1:0] trip_idx,
  input wire logic close_cmd,
  output logic [2:0] closed
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // commands read as plain levels: aux relays self reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      closed <= 3'h7;
      cnt <= 0;
    end else if (load) begin
      closed <= preset;
      cnt <= 0;
    end else if ((trip_cmd && closed[trip_idx]) ||
                 (close_cmd && !closed[2])) begin
      // slow mode stands for a sticky mechanism
      cnt <= (cnt == (slow ? 20 : 2)) ? 0 : cnt + 1;
      if (cnt == (slow ? 20 : 2)) begin
        if (trip_cmd) begin
          closed[trip_idx] <= 1'h0;
        end else begin
          closed[2] <= 1'h1;
        end
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule // field_model

// File: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, ce;
  logic [atc_pkg::ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, trip_out, load, slow;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, aux_relay;
  logic [1:0] bresp, rresp, trip_idx;
  logic [4:0] cin, el;
  logic [2:0] conn, preset, closed;
  logic [15:0] bus_voltage;
  int fail_count, checked, cyc;

  bus_auto_transfer_control bus_auto_transfer_control_inst (
    .clock(clock), .arst_n(arst_n), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .transformer_lockout_input(cin[0]), .source_trip_in(cin[1]),
    .block_transfer_in(cin[2]), .brk1_connected_in(conn[0]),
    .brk2_connected_in(conn[1]), .tie_connected_in(conn[2]),
    .brk1_closed_in(closed[0]), .brk2_closed_in(closed[1]),
    .tie_closed_in(closed[2]), .select_to_trip_in(cin[3]),
    .close_request_in(cin[4]), .uv_inverse_timeout(el[0]),
    .uv_definite_this(el[1]), .uv_definite_other(el[2]),
    .phase_instant_overcurrent(el[3]),
    .neutral_instant_overcurrent(el[4]), .bus_voltage(bus_voltage),
    .trip_out(trip_out), .aux_relay(aux_relay)
  );

  field_model field_model_inst (
    .clock(clock), .arst_n(arst_n), .load(load), .preset(preset),
    .slow(slow), .trip_cmd(trip_out), .trip_idx(trip_idx),
    .close_cmd(aux_relay[1]), .closed(closed)
  );

  always #2 clock = ~clock;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // ends on the falling edge after the last rising edge so outputs are settled
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic ta, tw, ga, gw, tb;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    ta = 1'h0;
    tw = 1'h0;
    while (!(ta && tw)) begin
      @(negedge clock);
      ga = !ta && awready === 1'h1;
      gw = !tw && wready === 1'h1;
      @(posedge clock);
      if (ga) begin
        awvalid <= 1'h0;
        ta = 1'h1;
      end
      if (gw) begin
        wvalid <= 1'h0;
        tw = 1'h1;
      end
    end
    tb = 1'h0;
    while (!tb) begin
      @(negedge clock);
      tb = bvalid === 1'h1;
      r = bresp;
      @(posedge clock);
    end
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic t;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    t = 1'h0;
    while (!t) begin
      @(negedge clock);
      t = arready === 1'h1;
      @(posedge clock);
    end
    arvalid <= 1'h0;
    t = 1'h0;
    while (!t) begin
      @(negedge clock);
      t = rvalid === 1'h1;
      d = rdata;
      r = rresp;
      @(posedge clock);
    end
    rready <= 1'h0;
  endtask

  task automatic ld(input logic [2:0] p);
    @(posedge clock);
    preset <= p;
    load <= 1'h1;
    @(posedge clock);
    load <= 1'h0;
  endtask

  task automatic normal(input logic [1:0] role);
    logic [1:0] r;
    @(posedge clock);
    cin <= 5'h00;
    el <= 5'h00;
    conn <= 3'h7;
    bus_voltage <= 16'hFFFF;
    trip_idx <= (role == 2'h3) ? 2'h2 : role - 2'h1;
    axw(atc_pkg::OFF_CTRL, {30'h0, role}, r);
    ld(3'h3);
    wt(4);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(atc_pkg::OFF_CTRL, d, r);
    chk(d, {30'h0, atc_pkg::CTRL_RST});
    axr(atc_pkg::OFF_POL, d, r);
    chk(d, {21'h0, atc_pkg::POL_RST});
    axr(atc_pkg::OFF_RESID, d, r);
    chk(d, {16'h0, atc_pkg::RESID_RST});
    axw(atc_pkg::OFF_STAT, 32'hFFFFFFFF, r);
    chk(r, atc_pkg::RESP_SLVERR);
    axw(8'h40, 32'h1, r);
    chk(r, atc_pkg::RESP_SLVERR);
    axr(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, atc_pkg::RESP_SLVERR);
    axw(atc_pkg::OFF_RESID, 32'hABCD1234, r);
    chk(r, atc_pkg::RESP_OKAY);
    axr(atc_pkg::OFF_RESID, d, r);
    chk(d, 32'h00001234);
  endtask

  task automatic t_block;
    for (int i = 0; i < 9; i++) begin
      normal(2'h1);
      @(posedge clock);
      case (i)
        0: cin[2] <= 1'h1;
        1, 2, 3: conn[i-1] <= 1'h0;
        4: begin
          preset <= 3'h1;
          load <= 1'h1;
        end
        5: el[3] <= 1'h1;
        6: el[4] <= 1'h1;
        7: el[2] <= 1'h1;
        default: el[1] <= 1'h1;
      endcase
      @(posedge clock);
      load <= 1'h0;
      wt(4);
      chk(aux_relay[2], {31'h0, i != 8});
      @(posedge clock);
      cin[0] <= 1'h1;
      wt(5);
      chk(trip_out, {31'h0, i == 8});
    end
  endtask

  task automatic t_xfer(input int cause, input logic s);
    normal(2'h1);
    @(posedge clock);
    slow <= s;
    if (cause == 2) begin
      el[0] <= 1'h1;
    end else begin
      cin[cause] <= 1'h1;
    end
    wt(3);
    chk(trip_out, 1'h1);
    wt(1);
    chk(aux_relay[0], 1'h1);
    while (closed[0] === 1'h1) begin
      chk(trip_out, 1'h1);
      wt(1);
    end
    wt(4);
    chk(trip_out, 1'h0);
    chk(aux_relay[0], 1'h1);
  endtask

  // cause raised while frozen must act only once ce returns
  task automatic t_ce;
    normal(2'h1);
    @(posedge clock);
    ce <= 1'h0;
    cin[0] <= 1'h1;
    wt(6);
    chk({trip_out, awready, wready, arready}, 4'h0);
    @(posedge clock);
    ce <= 1'h1;
    wt(4);
    chk(trip_out, 1'h1);
  endtask

  task automatic t_pol_inc2;
    logic [31:0] d;
    logic [1:0] r;
    normal(2'h1);
    axw(atc_pkg::OFF_POL, 32'h1 << atc_pkg::IN_BLOCK, r);
    wt(4);
    chk(aux_relay[2], 1'h1);
    axr(atc_pkg::OFF_STAT, d, r);
    chk(d, 32'h0000FC01);
    axw(atc_pkg::OFF_POL, 32'h1 << atc_pkg::IN_LOCKOUT, r);
    wt(4);
    chk(trip_out, 1'h1);
    axw(atc_pkg::OFF_POL, 32'h0, r);
    normal(2'h2);
    ld(3'h2);
    wt(4);
    chk(aux_relay[2], 1'h1);
    ld(3'h3);
    el[0] <= 1'h1;
    wt(5);
    chk(trip_out, 1'h1);
  endtask

  task automatic t_tie;
    logic [1:0] r;
    normal(2'h3);
    ld(3'h2);
    axw(atc_pkg::OFF_RESID, 32'h100, r);
    bus_voltage <= 16'h0101;
    cin[4] <= 1'h1;
    wt(4);
    @(posedge clock);
    cin[4] <= 1'h0;
    wt(4);
    chk(aux_relay[1], 1'h0);
    @(posedge clock);
    bus_voltage <= 16'h0100;
    wt(2);
    chk(aux_relay[1], 1'h1);
    while (closed[2] !== 1'h1) wt(1);
    wt(4);
    chk(aux_relay[1], 1'h0);
    ld(3'h2);
    cin[4] <= 1'h1;
    bus_voltage <= 16'hFFFF;
    wt(4);
    @(posedge clock);
    cin[4] <= 1'h0;
    cin[2] <= 1'h1;
    wt(4);
    @(posedge clock);
    cin[2] <= 1'h0;
    bus_voltage <= 16'h0000;
    wt(4);
    chk(aux_relay[1], 1'h0);
  endtask

  task automatic t_par;
    logic [1:0] r;
    normal(2'h3);
    ld(3'h7);
    cin[3] <= 1'h1;
    wt(4);
    chk(aux_relay[3], 1'h1);
    @(posedge clock);
    cin[3] <= 1'h0;
    wt(4);
    chk(aux_relay[3], 1'h0);
    @(posedge clock);
    cin[3] <= 1'h1;
    axw(atc_pkg::OFF_CTRL, 32'h0, r);
    ld(3'h7);
    cin[2] <= 1'h1;
    wt(4);
    chk({trip_out, aux_relay}, 5'h00);
  endtask

  initial begin
    clock = 1'h0;
    arst_n = 1'h0;
    ce = 1'h1;
    {awaddr, araddr, wdata, wstrb, bus_voltage} = '0;
    {awvalid, wvalid, bready, arvalid, rready, load, slow} = '0;
    {cin, el, preset, trip_idx} = '0;
    conn = 3'h7;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(posedge clock);
    arst_n <= 1'h1;
    t_regs();
    t_block();
    t_xfer(0, 1'h0);
    t_xfer(1, 1'h1);
    t_xfer(2, 1'h0);
    t_ce();
    t_pol_inc2();
    t_tie();
    t_par();
    tally_and_finish();
  end
endmodule // testbench
